// *** pcs_rx_elastic_fifo.v ***
`timescale 1ns/1ps
`default_nettype none
`include "rx_elastic_regs.vh"

module pcs_rx_elastic_fifo (
  input  wire                   clk,
  input  wire                   rst_n,
  input  wire [1:0]             fifo_mode,
  input  wire                   protocol_ilk,
  input  wire                   align_word_remove,
  input  wire                   ctrl_word_remove,
  input  wire                   frame_locked,
  input  wire                   block_locked,
  input  wire [4:0]             full_thresh,
  input  wire [4:0]             pfull_thresh,
  input  wire [4:0]             pempty_thresh,
  input  wire                   rx_in_valid,
  input  wire [`RXQ_WIDTH-1:0]  rx_in_data,
  output wire                   rx_in_ready,
  input  wire                   rx_out_ready,
  input  wire                   rxq_pop,
  input  wire                   lane_align_restart,
  input  wire                   lane_align_join,
  output reg  [`RXQ_WIDTH-1:0]  rx_out_data,
  output reg                    rx_word_qualifier_opt,
  output reg                    rxq_full_flag,
  output reg                    rxq_almost_full_flag,
  output reg                    rxq_empty_flag,
  output reg                    rxq_almost_empty_flag,
  output reg                    rxq_word_dropped,
  output reg                    rxq_word_added,
  output reg                    lane_align_found,
  output reg                    rx_clk_div_out
);
  // Word: [66] control flag, [65:64] sync header, [63:0] payload
  wire                  in_hdr_ctrl;
  wire                  in_sync;
  wire                  in_idle;
  wire                  is_ilk;
  wire                  is_cc;
  wire                  drop_word;
  wire                  wr_valid;
  wire                  wr_ready;
  wire                  f_valid;
  wire                  f_ready;
  wire [`RXQ_WIDTH-1:0] f_data;
  wire [`RXQ_CW-1:0]    f_count;
  wire                  qual_allowed;
  wire                  cc_delete;
  wire                  cc_insert;
  wire                  read_req;
  wire                  out_take;
  reg  [`RXQ_CW-1:0]    div_q;
  reg                   searching_q;
  reg  [`RXQ_WIDTH-1:0] last_idle_q;
  reg                   have_idle_q;

  assign is_ilk      = (fifo_mode == `RXQ_MODE_ILK) && protocol_ilk;
  assign is_cc       = (fifo_mode == `RXQ_MODE_CLKCOMP);
  assign in_hdr_ctrl = (rx_in_data[65:64] == `RXQ_HDR_CTRL);
  assign in_sync     = in_hdr_ctrl && (rx_in_data[63:58] == `RXQ_TYPE_SYNC);
  assign in_idle     = in_hdr_ctrl && (rx_in_data[63:56] == `RXQ_TYPE_IDLE);

  // Alignment removal needs frame lock only; control removal drops every control word
  assign drop_word = is_ilk && rx_in_valid &&
                     ((align_word_remove && frame_locked && in_sync) ||
                      (ctrl_word_remove && in_hdr_ctrl));

  // Idle delete at or above the partially full threshold; non-idle words still stall when full
  assign cc_delete = is_cc && block_locked && rx_in_valid && in_idle &&
                     (f_count >= {1'b0, pfull_thresh});

  assign wr_valid    = rx_in_valid && !drop_word && !cc_delete &&
                       !lane_align_restart;
  // Dropped words are consumed without needing space
  assign rx_in_ready = wr_ready || drop_word || cc_delete;

  // Interlaken reads only on pop and only after joining deskew
  assign read_req = is_ilk ? (rxq_pop && lane_align_join) : rx_out_ready;
  assign out_take = read_req && !lane_align_restart;
  assign f_ready  = out_take;

  // Insert repeats the last idle when the FIFO underruns
  assign cc_insert = is_cc && block_locked && out_take && !f_valid &&
                     have_idle_q;

  assign qual_allowed = protocol_ilk ? (fifo_mode == `RXQ_MODE_ILK) :
                        ((fifo_mode == `RXQ_MODE_PHASE) ||
                         (fifo_mode == `RXQ_MODE_REG));

  rxq_fifo #(
    .W  (`RXQ_WIDTH),
    .D  (`RXQ_DEPTH),
    .AW (`RXQ_AW),
    .CW (`RXQ_CW)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .flush     (lane_align_restart),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (rx_in_data),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data),
    .count     (f_count)
  );

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_out_data           <= {`RXQ_WIDTH{1'b0}};
      rx_word_qualifier_opt <= 1'b0;
      rxq_full_flag         <= 1'b0;
      rxq_almost_full_flag  <= 1'b0;
      rxq_empty_flag        <= 1'b1;
      rxq_almost_empty_flag <= 1'b1;
      rxq_word_dropped      <= 1'b0;
      rxq_word_added        <= 1'b0;
      lane_align_found      <= 1'b0;
      searching_q           <= 1'b1;
      last_idle_q           <= {`RXQ_WIDTH{1'b0}};
      have_idle_q           <= 1'b0;
    end else begin
      if (out_take && f_valid) begin
        rx_out_data <= f_data;
      end else if (cc_insert) begin
        rx_out_data <= last_idle_q;
      end
      rx_word_qualifier_opt <= qual_allowed &&
                               ((out_take && f_valid) || cc_insert);
      rxq_full_flag         <= (f_count >= {1'b0, full_thresh});
      rxq_almost_full_flag  <= (f_count >= {1'b0, pfull_thresh});
      rxq_empty_flag        <= (f_count == `RXQ_CNT_ZERO);
      rxq_almost_empty_flag <= (f_count <= {1'b0, pempty_thresh});
      rxq_word_dropped      <= cc_delete;
      rxq_word_added        <= cc_insert;
      if (rx_in_valid && in_idle) begin
        last_idle_q <= rx_in_data;
        have_idle_q <= 1'b1;
      end
      // Restart takes priority over a sync seen in the same cycle
      if (lane_align_restart) begin
        searching_q      <= 1'b1;
        lane_align_found <= 1'b0;
      end else if (is_ilk && searching_q && rx_in_valid && in_sync) begin
        searching_q      <= 1'b0;
        lane_align_found <= 1'b1;
      end else if (!is_ilk) begin
        lane_align_found <= 1'b0;
      end
    end
  end

  // Divide by 33: high for 16 cycles, low for 17
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q          <= `RXQ_CNT_ZERO;
      rx_clk_div_out <= 1'b0;
    end else begin
      if (div_q == `RXQ_CLK_HALF2) begin
        div_q <= `RXQ_CNT_ZERO;
      end else begin
        div_q <= div_q + `RXQ_CNT_ONE;
      end
      rx_clk_div_out <= (div_q < `RXQ_CLK_HALF);
    end
  end
endmodule // pcs_rx_elastic_fifo

`default_nettype wire

// *** pcs_rx_elastic_fifo_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module pcs_rx_elastic_fifo_checker (
  input wire logic       clk, rst_n, protocol_ilk, rx_out_ready, rxq_pop,
  input wire logic       lane_align_join, lane_align_restart, rx_word_qualifier_opt,
  input wire logic       rxq_full_flag, rxq_almost_full_flag, rxq_empty_flag,
  input wire logic       rxq_almost_empty_flag, rxq_word_dropped, rxq_word_added,
  input wire logic       lane_align_found, rx_clk_div_out,
  input wire logic [1:0] fifo_mode,
  input wire logic [4:0] full_thresh, pfull_thresh
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic       p_q, t_q;
  logic [5:0] r_q;
  // First run after reset is partial, so t_q waits for one toggle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p_q <= 1'b0;
      t_q <= 1'b0;
      r_q <= 6'h00;
    end else begin
      p_q <= rx_clk_div_out;
      t_q <= t_q | (rx_clk_div_out != p_q);
      r_q <= (rx_clk_div_out != p_q) ? 6'h01 : r_q + 6'h01;
    end
  end
  qual_cause_a: assert property (rx_word_qualifier_opt |->
    $past(rx_out_ready || rxq_pop && lane_align_join)) else $error("word out without read");
  qual_mode_a: assert property (rx_word_qualifier_opt |->
    $past(protocol_ilk) || $past(fifo_mode) >= 2'h2) else $error("qualifier in wrong mode");
  drop_mode_a: assert property (rxq_word_dropped |-> fifo_mode == 2'h1)
    else $error("drop pulse outside clock compensation");
  add_mode_a: assert property (rxq_word_added |-> fifo_mode == 2'h1)
    else $error("insert pulse outside clock compensation");
  found_clear_a: assert property (lane_align_restart |=> !lane_align_found)
    else $error("alignment found survives restart");
  flush_empty_a: assert property (lane_align_restart |-> ##2 rxq_empty_flag)
    else $error("restart did not empty fifo");
  full_empty_a: assert property (rxq_full_flag && full_thresh != 5'h00 |-> !rxq_empty_flag)
    else $error("full and empty together");
  full_pfull_a: assert property (rxq_full_flag && pfull_thresh <= full_thresh
    |-> rxq_almost_full_flag) else $error("full without partially full");
  empty_pempty_a: assert property (rxq_empty_flag |-> rxq_almost_empty_flag)
    else $error("empty without partially empty");
  div_period_a: assert property (t_q && rx_clk_div_out != p_q |->
    r_q == (p_q ? 6'h10 : 6'h11)) else $error("divided clock phase length");
endmodule // pcs_rx_elastic_fifo_checker
bind pcs_rx_elastic_fifo pcs_rx_elastic_fifo_checker pcs_rx_elastic_fifo_checker_inst (
  .clk, .rst_n, .protocol_ilk, .rx_out_ready, .rxq_pop, .lane_align_join,
  .lane_align_restart, .rx_word_qualifier_opt, .rxq_full_flag, .rxq_almost_full_flag,
  .rxq_empty_flag, .rxq_almost_empty_flag, .rxq_word_dropped, .rxq_word_added,
  .lane_align_found, .rx_clk_div_out, .fifo_mode, .full_thresh, .pfull_thresh);
`default_nettype wire

// *** pcs_rx_elastic_fifo_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module pcs_rx_elastic_fifo_tb;
  logic clk = 1'b0, rst_n = 1'b0, protocol_ilk = 1'b0, awr = 1'b0, cwr = 1'b0, rd;
  logic frame_locked = 1'b1, rx_in_valid = 1'b0, lane_align_restart = 1'b0, chk_on = 1'b1;
  logic lane_align_join = 1'b1, go = 1'b0, slow = 1'b0, rx_in_ready, qual, full, afull;
  logic empty, aempty, dropped, added, found;
  logic [1:0]  fifo_mode = 2'h2;
  logic [66:0] rx_in_data = 67'h0, rx_out_data;
  logic [66:0] exp_q[$];
  int seed = 32'h5e1c, n_mismatch = 0, cmp_count = 0, n_in = 0, n_drop = 0, n_add = 0;
  always #2 clk = ~clk;
  pcs_rx_elastic_fifo pcs_rx_elastic_fifo_inst (.clk, .rst_n, .fifo_mode, .protocol_ilk,
    .align_word_remove(awr), .ctrl_word_remove(cwr), .frame_locked, .block_locked(1'b1),
    .full_thresh(5'h1f), .pfull_thresh(5'h17), .pempty_thresh(5'h02), .rx_in_valid,
    .rx_in_data, .rx_in_ready, .rx_out_ready(rd), .rxq_pop(rd), .lane_align_restart,
    .lane_align_join, .rx_out_data, .rx_word_qualifier_opt(qual), .rxq_full_flag(full),
    .rxq_almost_full_flag(afull), .rxq_empty_flag(empty), .rxq_almost_empty_flag(aempty),
    .rxq_word_dropped(dropped), .rxq_word_added(added), .lane_align_found(found),
    .rx_clk_div_out());
  rx_fabric_reader rx_fabric_reader_inst (.clk, .rst_n, .go, .slow, .rd);
  // Kind 0 data, 1 mixed data/control/sync, 2 idle
  function automatic logic [66:0] gen(input int k);
    logic [63:0] p;
    p = {$random(seed), $random(seed)};
    if (k == 1 && p[1]) p[63:58] = 6'h1e;
    if (k == 2) p[63:56] = 8'h1e;
    return {1'b0, (k == 0 || (k == 1 && p[0])) ? 2'h1 : 2'h2, p};
  endfunction
  function automatic bit keep(input logic [66:0] w);
    if (!protocol_ilk || w[65:64] != 2'h2) return 1'b1;
    return !(cwr || awr && frame_locked && w[63:58] == 6'h1e);
  endfunction
  task automatic cmp(input logic [66:0] g, e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic close_out;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // A word refused for 12 cycles is abandoned and not expected
  task automatic send_n(input int n, k);
    int t;
    logic [66:0] w;
    for (int i = 0; i < n; i++) begin
      w = gen(k);
      rx_in_valid <= 1'b1;
      rx_in_data <= w;
      for (t = 0; t < 12; t++) begin
        @(negedge clk);
        if (rx_in_ready === 1'b1) break;
        @(posedge clk);
      end
      if (t < 12) begin
        @(posedge clk);
        n_in++;
        if (keep(w)) exp_q.push_back(w);
      end
    end
    rx_in_valid <= 1'b0;
  endtask
  task automatic drain;
    go <= 1'b1;
    for (int t = 0; t < 600 && exp_q.size() > 0; t++) @(posedge clk);
    repeat (4) @(posedge clk);
    @(negedge clk);
    cmp(67'(exp_q.size()), 67'h0);
    cmp(67'(empty), 67'h1);
    cmp(67'(aempty), 67'h1);
    @(posedge clk);
  endtask
  always @(negedge clk) begin
    if (dropped === 1'b1) n_drop++;
    if (added === 1'b1) n_add++;
    if (chk_on && qual === 1'b1)
      cmp(rx_out_data, exp_q.size() ? exp_q.pop_front() : ~rx_out_data);
  end
  initial begin
    #60000;
    n_mismatch++;
    close_out;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    send_n(40, 0);
    repeat (2) @(posedge clk);
    @(negedge clk);
    cmp(67'(n_in), 67'd32);
    cmp(67'(rx_in_ready), 67'h0);
    cmp(67'(full), 67'h1);
    cmp(67'(afull), 67'h1);
    @(posedge clk);
    drain;
    slow <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      fifo_mode <= (i < 2) ? 2'(i + 2) : 2'h0;
      protocol_ilk <= (i > 1);
      cwr <= (i == 3);
      awr <= (i == 3);
      @(posedge clk);
      send_n(60, (i > 1) ? 1 : 0);
      drain;
    end
    @(negedge clk);
    cmp(67'(found), 67'h1);
    @(posedge clk);
    go <= 1'b0;
    send_n(10, 0);
    lane_align_join <= 1'b0;
    go <= 1'b1;
    repeat (20) @(posedge clk);
    @(negedge clk);
    cmp(67'(empty), 67'h0);
    @(posedge clk);
    go <= 1'b0;
    lane_align_join <= 1'b1;
    repeat (2) @(posedge clk);
    lane_align_restart <= 1'b1;
    @(posedge clk);
    lane_align_restart <= 1'b0;
    exp_q.delete();
    repeat (2) @(posedge clk);
    @(negedge clk);
    cmp(67'(empty), 67'h1);
    cmp(67'(found), 67'h0);
    @(posedge clk);
    send_n(12, 1);
    drain;
    go <= 1'b0;
    chk_on <= 1'b0;
    protocol_ilk <= 1'b0;
    fifo_mode <= 2'h1;
    @(posedge clk);
    send_n(24, 0);
    @(posedge clk);
    send_n(3, 2);
    slow <= 1'b0;
    go <= 1'b1;
    repeat (60) @(posedge clk);
    send_n(2, 2);
    repeat (60) @(posedge clk);
    @(negedge clk);
    cmp(67'(n_drop > 0), 67'h1);
    cmp(67'(n_add > 0), 67'h1);
    close_out;
  end
endmodule // pcs_rx_elastic_fifo_tb
`default_nettype wire

// *** rx_elastic_regs.vh ***
`ifndef RX_ELASTIC_REGS_VH
`define RX_ELASTIC_REGS_VH

`define RXQ_WIDTH        67
`define RXQ_DEPTH        32
`define RXQ_AW           5
`define RXQ_CW           6
`define RXQ_FULL_DEF     5'h1f
`define RXQ_PFULL_DEF    5'h17
`define RXQ_PEMPTY_DEF   5'h02
`define RXQ_CLK_DIV      6'h21
`define RXQ_CLK_HALF     6'h10
`define RXQ_CLK_HALF2    6'h20
`define RXQ_CNT_ZERO     6'h00
`define RXQ_CNT_ONE      6'h01
`define RXQ_PTR_ONE      5'h01
`define RXQ_HDR_CTRL     2'h2
`define RXQ_TYPE_SYNC    6'h1e
`define RXQ_TYPE_IDLE    8'h1e
`define RXQ_MODE_ILK     2'h0
`define RXQ_MODE_CLKCOMP 2'h1
`define RXQ_MODE_PHASE   2'h2
`define RXQ_MODE_REG     2'h3
`define RXQ_PROT_BASIC   1'b0
`define RXQ_PROT_ILK     1'b1

`endif

// *** rx_fabric_reader.sv ***
`timescale 1ns/1ps
`default_nettype none
module rx_fabric_reader (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic go,
  input  wire logic slow,
  output var  logic rd
);
  int s = 32'h0a11;
  // Slow mode stalls three cycles in four on average
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) rd <= 1'b0;
    else rd <= go && (!slow || ($random(s) & 3) == 0);
  end
endmodule // rx_fabric_reader
`default_nettype wire

// *** rxq_fifo.v ***
`timescale 1ns/1ps
`default_nettype none
`include "rx_elastic_regs.vh"

// Flop-based FIFO, valid/ready on both sides
module rxq_fifo #(
  parameter W  = `RXQ_WIDTH,
  parameter D  = `RXQ_DEPTH,
  parameter AW = `RXQ_AW,
  parameter CW = `RXQ_CW
) (
  input  wire          clk,
  input  wire          rst_n,
  input  wire          flush,
  input  wire          in_valid,
  output wire          in_ready,
  input  wire [W-1:0]  in_data,
  output wire          out_valid,
  input  wire          out_ready,
  output wire [W-1:0]  out_data,
  output wire [CW-1:0] count
);
  reg [W-1:0]  mem_q [0:D-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [CW-1:0] cnt_q;
  wire         push;
  wire         pop;
  genvar       i;

  assign in_ready  = (cnt_q != D[CW-1:0]);
  assign out_valid = (cnt_q != `RXQ_CNT_ZERO);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_q[rp_q];
  assign count     = cnt_q;

  generate
    for (i = 0; i < D; i = i + 1) begin : g_ent
      localparam [AW-1:0] SLOT = i;
      always @(posedge clk) begin
        if (push && wp_q == SLOT) begin
          mem_q[i] <= in_data;
        end
      end
    end
  endgenerate

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q <= {CW{1'b0}};
    end else if (flush) begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q <= {CW{1'b0}};
    end else begin
      if (push) begin
        wp_q <= wp_q + `RXQ_PTR_ONE;
      end
      if (pop) begin
        rp_q <= rp_q + `RXQ_PTR_ONE;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + `RXQ_CNT_ONE;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - `RXQ_CNT_ONE;
      end
    end
  end
endmodule // rxq_fifo

`default_nettype wire
